/* File: src/sld_top.sv */
/*
 * segment display controller: apb registers, clock prescaler and divider,
 * frame sequencer, display data latch, buffer drive timer, terminal levels.
 * assumes an apb master on pclk and an analog back end that turns the
 * registered terminal levels and enables into pin voltages.
 */
`timescale 1ns/100ps

module sld_top #(
    parameter int SEG_N = 40                       // segment terminals built
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_oscillator_input,
    input wire logic contrast_supply_ok,
    input wire sld_pkg::sld_sleep_t sleep_mode,
    output sld_pkg::sld_pin_t [sld_pkg::NCOM-1:0] com_pin,
    output sld_pkg::sld_pin_t [SEG_N-1:0] seg_pin,
    output logic frame_irq,
    output logic buffers_on,
    output logic [3:0] contrast_level
);
    import sld_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // functions
    // memory decode: {hit, index}
    function automatic logic [5:0] mem_dec(input logic [11:0] a);
        logic [11:0] d;
        d = a - OFS_MEM;
        mem_dec = {(a >= OFS_MEM) && (d[1:0] == 2'h0) && (d[11:2] < 10'(NMEM)), d[6:2]};
    endfunction : mem_dec

    // prescaler divide factor
    function automatic logic [12:0] ps_div(input logic [2:0] s);
        case (s)
            3'h0: ps_div = 13'h0010;
            3'h1: ps_div = 13'h0040;
            3'h2: ps_div = 13'h0080;
            3'h3: ps_div = 13'h0100;
            3'h4: ps_div = 13'h0200;
            3'h5: ps_div = 13'h0400;
            3'h6: ps_div = 13'h0800;
            default: ps_div = 13'h1000;
        endcase
    endfunction : ps_div

    // terminal level for an addressed/on (hit) or other terminal
    function automatic logic [2:0] lvl_of(input logic com_side, input logic hit,
                                          input logic pol, input logic stat,
                                          input logic half);
        if (hit || stat) begin
            lvl_of = ((com_side == hit) ^ pol) ? LVL_FULL : LVL_GND;
        end else if (half) begin
            // half bias: only commons take the middle level, off segments
            // follow the addressed common's rail so they stay in phase
            lvl_of = com_side ? LVL_HALF : (pol ? LVL_GND : LVL_FULL);
        end else begin
            lvl_of = ((com_side ^ pol)) ? LVL_THIRD : LVL_TWO_THIRD;
        end
    endfunction : lvl_of

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic en_r, lpw_r, flag_r, ie_r, blank_r;      // control a
    logic cs_r, half_r;                            // control b
    logic [1:0] duty_r;
    logic [5:0] segs_r;
    logic [2:0] ps_r, cd_r, dt_r;                  // frame rate, drive time
    logic [3:0] lvl_r;                             // contrast setting
    logic prr_r;                                   // power reduction
    logic [7:0] mem_r [NMEM];                      // display memory
    logic [SEG_MAX-1:0] lat_r [NCOM];              // latched display data
    logic lpw_l, blank_l;                          // per-frame latched controls
    logic [11:0] ps_cnt_r;
    logic [2:0] cd_cnt_r;
    logic [15:0] drive_cnt_r;
    logic [1:0] com_r;                             // addressed common
    logic phase_r;                                 // waveform polarity
    sld_state_t state_r;
    logic tosc_rise, supply_ok;
    logic act, run_ok, src_tick, ps_tick, tim_tick, wrap, latch_ev, wr, buf_on;
    logic [2:0] ncom;
    logic [11:0] ps_mask;
    logic [15:0] half_per, dt_len, load_len;
    logic [5:0] md;
    logic [12:0] ps_full;                          // selected prescale factor
    logic sync_unused, rise_unused;                // level of timer pin, supply rise

    sld_sync #(.W(2)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d_in({contrast_supply_ok, timer_oscillator_input}),
        .level({supply_ok, sync_unused}),
        .rise({rise_unused, tosc_rise})
    );

    ////////////////////////////////////////////////////////////////////////////
    // combinational timing terms
    always_comb begin
        act = en_r & ~prr_r;
        run_ok = (sleep_mode == SLP_ACTIVE) || (sleep_mode == SLP_IDLE) ||
                 (sleep_mode == SLP_POWER_SAVE) ||
                 (cs_r && sleep_mode == SLP_ADC_NR);
        src_tick = act & run_ok & (cs_r ? tosc_rise : 1'b1);
        ps_full = ps_div(ps_r);
        ps_mask = ps_full[11:0] - 12'h001;
        ps_tick = src_tick & ((ps_cnt_r & ps_mask) == ps_mask);
        tim_tick = ps_tick & (cd_cnt_r == cd_r) & (state_r == ST_RUN);
        ncom = {1'b0, duty_r} + 3'h1;
        wrap = tim_tick & (lpw_l | phase_r) & ({1'b0, com_r} == ncom - 3'h1);
        latch_ev = (wrap & phase_r) | (state_r == ST_WAIT & supply_ok);
        wr = psel & penable & pready & pwrite;
        md = mem_dec(paddr);
        half_per = (16'(ps_div(ps_r)) * (16'(cd_r) + 16'h0001)) >> 1;
        dt_len = (16'(dt_r) + 16'h0001) * DRIVE_STEP;
        load_len = (ncom > 3'h1 && dt_len > half_per) ? half_per : dt_len;
        buf_on = drive_cnt_r != 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_r, lpw_r, ie_r, blank_r} <= {RST_CTRL_A[CA_EN], RST_CTRL_A[CA_LPW],
                                             RST_CTRL_A[CA_IE], RST_CTRL_A[CA_BLANK]};
            cs_r <= RST_CTRL_B[CB_CS];
            half_r <= RST_CTRL_B[CB_HALF];
            duty_r <= RST_CTRL_B[CB_DUTY+:2];
            segs_r <= RST_CTRL_B[CB_SEGS+:6];
            {ps_r, cd_r} <= {RST_FRAME[FR_PS+:3], RST_FRAME[FR_CD+:3]};
            {dt_r, lvl_r} <= {RST_CONTRAST[CC_DT+:3], RST_CONTRAST[CC_LVL+:4]};
            prr_r <= RST_POWER[PW_LCD];
        end else if (ce && wr) begin
            case (paddr)
                OFS_CTRL_A: begin
                    en_r <= pwdata[CA_EN];
                    lpw_r <= pwdata[CA_LPW];
                    ie_r <= pwdata[CA_IE];
                    blank_r <= pwdata[CA_BLANK];
                end
                OFS_CTRL_B: begin
                    cs_r <= pwdata[CB_CS];
                    half_r <= pwdata[CB_HALF];
                    duty_r <= pwdata[CB_DUTY+:2];
                    segs_r <= pwdata[CB_SEGS+:6];
                end
                OFS_FRAME: begin
                    ps_r <= pwdata[FR_PS+:3];
                    cd_r <= pwdata[FR_CD+:3];
                end
                OFS_CONTRAST: begin
                    dt_r <= pwdata[CC_DT+:3];
                    lvl_r <= pwdata[CC_LVL+:4];
                end
                OFS_POWER: prr_r <= pwdata[PW_LCD];
                default: ;
            endcase
        end
    end

    // display memory writes, free at any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NMEM; i++) mem_r[i] <= RST_MEM;
        end else if (ce && wr && md[5]) begin
            mem_r[md[4:0]] <= pwdata[7:0];
        end
    end

    // frame flag: set wins over the write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            flag_r <= latch_ev | (flag_r & ~(wr & paddr == OFS_CTRL_A & pwdata[CA_FLAG]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: data loaded in setup, ready for the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~md[5] & (paddr != OFS_CTRL_A) &
                       (paddr != OFS_CTRL_B) & (paddr != OFS_FRAME) &
                       (paddr != OFS_CONTRAST) & (paddr != OFS_POWER);
            case (paddr)
                OFS_CTRL_A: prdata <= {24'h0, en_r, lpw_r, 1'b0, flag_r, ie_r,
                                       ~buf_on, supply_ok, blank_r};
                OFS_CTRL_B: prdata <= {24'h0, cs_r, half_r, segs_r}; // duty shares bits 5:4
                OFS_FRAME: prdata <= {24'h0, 1'b0, ps_r, 1'b0, cd_r};
                OFS_CONTRAST: prdata <= {24'h0, dt_r, 1'b0, lvl_r};
                OFS_POWER: prdata <= {31'h0, prr_r};
                default: prdata <= md[5] ? {24'h0, mem_r[md[4:0]]} : 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // prescaler and divider, held clear while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ps_cnt_r <= 12'h000;
            cd_cnt_r <= 3'h0;
        end else if (ce) begin
            if (!act) begin
                ps_cnt_r <= 12'h000;
                cd_cnt_r <= 3'h0;
            end else begin
                if (src_tick) ps_cnt_r <= ps_cnt_r + 12'h001;
                if (ps_tick) cd_cnt_r <= (cd_cnt_r == cd_r) ? 3'h0 : cd_cnt_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_OFF;
            com_r <= 2'h0;
            phase_r <= 1'b0;
        end else if (ce) begin
            case (state_r)
                ST_OFF: if (act) state_r <= ST_WAIT;
                ST_WAIT: begin
                    com_r <= 2'h0;
                    phase_r <= 1'b0;
                    if (!act) state_r <= ST_OFF;
                    else if (supply_ok) state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (!act) begin
                        state_r <= ST_OFF;
                    end else if (tim_tick) begin
                        if (lpw_l | phase_r) begin
                            com_r <= wrap ? 2'h0 : com_r + 2'h1;
                        end
                        if (!lpw_l || wrap) phase_r <= ~phase_r;
                    end
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

    // data latch before each frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCOM; c++) lat_r[c] <= '0;
            lpw_l <= 1'b0;
            blank_l <= 1'b0;
            contrast_level <= 4'h0;
        end else if (ce && latch_ev) begin
            for (int c = 0; c < NCOM; c++) begin
                for (int b = 0; b < MEM_PER_COM; b++) begin
                    lat_r[c][b*8+:8] <= mem_r[c*MEM_PER_COM+b];
                end
            end
            lpw_l <= lpw_r;
            blank_l <= blank_r;
            contrast_level <= lvl_r;
        end
    end

    // buffer drive timer, reloaded at every transition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_cnt_r <= 16'h0000;
        end else if (ce) begin
            if (!act) drive_cnt_r <= 16'h0000;
            else if (tim_tick || latch_ev) drive_cnt_r <= load_len;
            else if (src_tick && buf_on) drive_cnt_r <= drive_cnt_r - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // terminal outputs, registered
    for (genvar c = 0; c < NCOM; c++) begin : g_com
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                com_pin[c] <= '0;
            end else if (ce) begin
                com_pin[c].own <= act & (3'(c) < ncom);
                com_pin[c].lvl <= (blank_l || state_r != ST_RUN) ? LVL_GND :
                    lvl_of(1'b1, com_r == 2'(c), phase_r, duty_r == 2'h0, half_r);
                com_pin[c].oe <= act & (state_r == ST_RUN) & (3'(c) < ncom) &
                    (blank_l | buf_on | duty_r == 2'h0 | com_r == 2'(c));
            end
        end
    end

    for (genvar s = 0; s < SEG_N; s++) begin : g_seg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                seg_pin[s] <= '0;
            end else if (ce) begin
                seg_pin[s].own <= act & (6'(s) < segs_r);
                seg_pin[s].lvl <= (blank_l || state_r != ST_RUN) ? LVL_GND :
                    lvl_of(1'b0, lat_r[com_r][s], phase_r, duty_r == 2'h0, half_r);
                seg_pin[s].oe <= act & (state_r == ST_RUN) & (6'(s) < segs_r) &
                    (blank_l | buf_on | duty_r == 2'h0 | half_r | lat_r[com_r][s]);
            end
        end
    end

    // interrupt request and buffer status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_irq <= 1'b0;
            buffers_on <= 1'b0;
        end else if (ce) begin
            frame_irq <= flag_r & ie_r;
            buffers_on <= buf_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk iff ce); endclocking
    default disable iff (!presetn);

    flag_set_a: assert property (latch_ev |=> flag_r) else $error("flag not set");
    off_now_a: assert property (!act |=> state_r == ST_OFF) else $error("not off");
    inhibit_out_a: assert property (state_r == ST_WAIT |=> !com_pin[0].oe)
        else $error("driven before supply ready");
    drive_cap_a: assert property (tim_tick && ncom > 3'h1 && act |=> drive_cnt_r <= half_per)
        else $error("drive exceeds half period");
    first_com_a: assert property (latch_ev && act |=> com_r == 2'h0)
        else $error("frame not at first common");
    cnt_clear_a: assert property (!act |=> ps_cnt_r == 12'h000 && cd_cnt_r == 3'h0)
        else $error("counters run while off");
    blank_gnd_a: assert property (state_r == ST_RUN && blank_l |=> seg_pin[0].lvl == LVL_GND)
        else $error("blank not grounded");
    mem_latch_a: assert property (latch_ev |=> lat_r[0][7:0] == $past(mem_r[0]))
        else $error("latch missed memory");
    lp_hold_a: assert property (wrap && lpw_l && !phase_r |=> $stable(lat_r[1]))
        else $error("low power latched early");
endmodule : sld_top

/* File: src/sld_pkg.sv */
/*
 * shared constants and types for the segment display controller:
 * register offsets, field positions, reset values, levels and states.
 * assumes a 32-bit apb register bus with a 12-bit byte address.
 */
package sld_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int NCOM = 4;                       // common terminals
    localparam int NMEM = 20;                      // display memory bytes
    localparam int SEG_MAX = 40;                   // segment terminals
    localparam int MEM_PER_COM = 5;                // memory bytes per common

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [11:0] OFS_CTRL_A = 12'h0E4;  // control and status a
    localparam logic [11:0] OFS_CTRL_B = 12'h0E8;  // display_control_b
    localparam logic [11:0] OFS_FRAME = 12'h0EC;   // prescale and divide
    localparam logic [11:0] OFS_CONTRAST = 12'h0F0; // contrast_control
    localparam logic [11:0] OFS_POWER = 12'h0F4;   // power_reduction_reg
    localparam logic [11:0] OFS_MEM = 12'h100;     // display_memory_reg 0

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CA_EN = 7;                      // display_enable
    localparam int CA_LPW = 6;                     // low_power_waveform_sel
    localparam int CA_FLAG = 4;                    // frame_start_flag, write one clears
    localparam int CA_IE = 3;                      // frame_irq_enable
    localparam int CA_BUFOFF = 2;                  // buffers switched off, read only
    localparam int CA_READY = 1;                   // contrast supply ready, read only
    localparam int CA_BLANK = 0;                   // display_blank
    localparam int CB_CS = 7;                      // display_clock_select
    localparam int CB_HALF = 6;                    // one: half bias, zero: third bias
    localparam int CB_DUTY = 4;                    // two bits: commons in use minus one
    localparam int CB_SEGS = 0;                    // six bits: segment terminals in use
    localparam int FR_PS = 4;                      // display_prescale_select
    localparam int FR_CD = 0;                      // display_clock_divide
    localparam int CC_DT = 5;                      // buffer_drive_time
    localparam int CC_LVL = 0;                     // four bits: contrast level
    localparam int PW_LCD = 0;                     // display_power_reduction

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_FRAME = 8'h00;
    localparam logic [7:0] RST_CONTRAST = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_MEM = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timing: buffer drive step in display source clock ticks
    localparam logic [15:0] DRIVE_STEP = 16'h0008;

    // output levels in sixths of the contrast supply voltage
    localparam logic [2:0] LVL_GND = 3'h0;
    localparam logic [2:0] LVL_THIRD = 3'h2;
    localparam logic [2:0] LVL_HALF = 3'h3;
    localparam logic [2:0] LVL_TWO_THIRD = 3'h4;
    localparam logic [2:0] LVL_FULL = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,                           // display off, pins released
        ST_WAIT = 3'b010,                          // waiting for contrast supply
        ST_RUN = 3'b100                            // frames running
    } sld_state_t;

    typedef enum logic [2:0] {
        SLP_ACTIVE = 3'h0,
        SLP_IDLE = 3'h1,
        SLP_ADC_NR = 3'h2,
        SLP_POWER_SAVE = 3'h3,
        SLP_POWER_DOWN = 3'h4,
        SLP_STANDBY = 3'h5
    } sld_sleep_t;

    // one display terminal: owned by the display, driven, level
    typedef struct packed {
        logic own;
        logic oe;
        logic [2:0] lvl;
    } sld_pin_t;
endpackage : sld_pkg

/* File: src/sld_sync.sv */
/*
 * three-flop input synchroniser with agreement filter and rise pulse.
 * assumes inputs from outside the pclk domain; all state frozen by ce.
 */
`timescale 1ns/100ps
module sld_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    import sld_pkg::*;

    logic [W-1:0] s1_r;                            // first stage, read only by s2
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // shift chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else if (ce) begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= '0;
            rise <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level[i] <= s3_r[i];
                    rise[i] <= s3_r[i] & ~level[i];
                end else begin
                    rise[i] <= 1'b0;
                end
            end
        end
    end
endmodule : sld_sync

/* File: tb/sld_panel.sv */
/*
 * panel model: tells which of two segments on the first common look lit.
 * assumes rail levels in sixths of the supply, static drive.
 */
`timescale 1ns/100ps
module sld_panel (
    input wire sld_pkg::sld_pin_t common_terminal_first,
    input wire sld_pkg::sld_pin_t [1:0] seg,
    output logic [1:0] lit
);
    import sld_pkg::*;
    // lit when the segment sees the full swing against its common
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            lit[i] = common_terminal_first.oe && seg[i].oe && ((common_terminal_first.lvl ^ seg[i].lvl) == LVL_FULL);
        end
    end
endmodule : sld_panel

/* File: tb/sld_top_tb_top.sv */
/*
 * bench for the segment display controller: apb tasks and a static frame run.
 * assumes the panel model and a 4 ns pclk.
 */
`timescale 1ns/100ps
module sld_top_tb_top;
    import sld_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ok = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, frame_irq, buffers_on, er;
    logic tosc = 0, hi, lo;                          // timer pin, buffer activity seen
    sld_sleep_t sleep_mode = SLP_ACTIVE;
    sld_pin_t [NCOM-1:0] com_pin;
    sld_pin_t [SEG_MAX-1:0] seg_pin;
    logic [3:0] contrast_level;
    logic [1:0] lit;
    int fail_count = 0, checked = 0, cyc = 0;
    sld_top u_sld_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_oscillator_input(tosc), .contrast_supply_ok(ok), .sleep_mode(sleep_mode),
        .com_pin(com_pin), .seg_pin(seg_pin), .frame_irq(frame_irq),
        .buffers_on(buffers_on), .contrast_level(contrast_level));
    sld_panel u_sld_panel (.common_terminal_first(com_pin[0]), .seg(seg_pin[1:0]), .lit(lit));
    initial forever #2 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        // timer pin: one rising edge every eight clocks
        if (cyc % 4 == 0) tosc <= ~tosc;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready, then releases
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0000_00, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // poll until the start-of-frame flag reads one
    task automatic wait_flag();
        do apb(0, OFS_CTRL_A, 8'h00); while (rd[CA_FLAG] !== 1'b1);
    endtask : wait_flag
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_CTRL_A, 8'h00);
        chk(rd[7:0], RST_CTRL_A | (8'h01 << CA_BUFOFF));
        apb(0, 12'h0FC, 8'h00);
        chk({7'h00, er}, 8'h01);
        apb(1, OFS_MEM, 8'h01);
        apb(1, OFS_CTRL_B, 8'h02);
        apb(1, OFS_FRAME, 8'h00);
        apb(1, OFS_CONTRAST, 8'h0A);
        apb(1, OFS_POWER, 8'h01);
        apb(1, OFS_CTRL_A, 8'h88);
        repeat (8) @(posedge pclk);
        chk({7'h00, com_pin[0].own}, 8'h00);
        apb(1, OFS_POWER, 8'h00);
        repeat (8) @(posedge pclk);
        chk({7'h00, com_pin[0].oe}, 8'h00);
        ok <= 1;
        // poll for the start-of-frame flag
        wait_flag();
        chk({7'h00, frame_irq}, 8'h01);
        chk({6'h00, lit}, 8'h01);
        chk({7'h00, seg_pin[2].own}, 8'h00);
        chk({7'h00, com_pin[1].own}, 8'h00);
        chk({4'h0, contrast_level}, 8'h0A);
        // drive timer: on for half of each timing tick in static drive
        hi = 1'b0;
        lo = 1'b0;
        repeat (32) begin
            @(posedge pclk);
            hi = hi | buffers_on;
            lo = lo | ~buffers_on;
        end
        chk({6'h00, hi, lo}, 8'h03);
        // power-down stops the io-clocked display, idle runs it again
        sleep_mode <= SLP_POWER_DOWN;
        apb(1, OFS_CTRL_A, 8'h98);
        repeat (100) @(posedge pclk);
        apb(0, OFS_CTRL_A, 8'h00);
        chk({7'h00, rd[CA_FLAG]}, 8'h00);
        sleep_mode <= SLP_IDLE;
        wait_flag();
        apb(1, OFS_CTRL_A, 8'h18);
        repeat (2) @(posedge pclk);
        chk({7'h00, com_pin[0].own}, 8'h00);
        // timer-pin clock, four commons, low power waveform, then blanking
        apb(1, OFS_CTRL_B, 8'hB0);
        apb(1, OFS_CONTRAST, 8'hE5);
        sleep_mode <= SLP_ADC_NR;
        apb(1, OFS_CTRL_A, 8'hD8);
        wait_flag();
        chk({4'h0, contrast_level}, 8'h05);
        apb(1, OFS_CTRL_A, 8'hD9);
        wait_flag();
        apb(1, OFS_CTRL_A, 8'hD9);
        wait_flag();
        chk({5'h00, seg_pin[0].lvl}, {5'h00, LVL_GND});
        chk({5'h00, com_pin[3].lvl}, {5'h00, LVL_GND});
        chk({7'h00, seg_pin[39].own}, 8'h01);
        final_report();
    end
endmodule : sld_top_tb_top
